// ===== flash_prot_host.sv
// Purpose: apb-driven host that runs flash bus cycles for group protection
// Assumes: flash pins asynchronous; external switch puts reset pin at
//          high_voltage_level while hv_request is high
// Notes:   zero-wait apb slave; one flash cycle at a time
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ns

module flash_prot_host (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // flash bus
    output logic [flash_prot_pkg::ADDR_W-1:0] flash_addr,
    output logic [flash_prot_pkg::DATA_W-1:0] dq_out,
    output logic dq_oe,
    input wire logic [flash_prot_pkg::DATA_W-1:0] dq_in,
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    // protection controls
    output logic flash_reset_n,
    output logic hv_request,
    output logic guard_n
);

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_SETUP = 5'b00010,
        ST_STROBE = 5'b00100,
        ST_SETTLE = 5'b01000,
        ST_HOLD = 5'b10000
    } state_t;

    localparam int AW = flash_prot_pkg::ADDR_W;
    localparam int DW = flash_prot_pkg::DATA_W;

    if (!(flash_prot_pkg::STROBE_CYC inside {[1:7]})) begin : g_strobe_chk
        $error("strobe count out of counter range");
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [AW-1:0] addr_reg, next_addr_reg;
    logic [DW-1:0] wdata_reg, next_wdata_reg;
    logic [3:0] ctrl, next_ctrl;
    logic [DW-1:0] rdata_reg, next_rdata_reg;
    logic [31:0] pmap, next_pmap;
    logic refused, next_refused;
    logic done, next_done;
    state_t state, next_state;
    flash_prot_pkg::op_t op, next_op;
    logic [2:0] cnt, next_cnt;
    logic [DW-1:0] dq_sync;

    logic wr_en, rd_en, mapped, start, refuse, busy;
    logic [31:0] rd_mux;

    flash_pin_sync #(.WIDTH(DW)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(dq_in),
        .pin_sync(dq_sync)
    );

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    assign busy = state != ST_IDLE;
    assign wr_en = psel && penable && pwrite && mapped;
    assign rd_en = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign start = wr_en && paddr == flash_prot_pkg::CMD_OFF;

    always_comb begin
        mapped = 1'b1;
        rd_mux = '0;
        case (paddr)
            flash_prot_pkg::ADDR_OFF: rd_mux = {10'h000, addr_reg};
            flash_prot_pkg::WDATA_OFF: rd_mux = {16'h0000, wdata_reg};
            flash_prot_pkg::CTRL_OFF: rd_mux = {28'h000_0000, ctrl};
            flash_prot_pkg::CMD_OFF: rd_mux = '0;
            flash_prot_pkg::STATUS_OFF: rd_mux = {29'h0000_0000, done,
                                                  refused, busy};
            flash_prot_pkg::RDATA_OFF: rd_mux = {16'h0000, rdata_reg};
            flash_prot_pkg::PMAP_OFF: rd_mux = pmap;
            default: mapped = 1'b0;
        endcase
    end

    // refusal of a command before any pin moves
    always_comb begin
        refuse = busy;
        if (pwdata[1:0] == flash_prot_pkg::OP_UNPROT) begin
            // unprotect needs high voltage and every group protected
            if (!ctrl[flash_prot_pkg::CTRL_HV_BIT]) refuse = 1'b1;
            if (pmap != 32'hFFFF_FFFF) refuse = 1'b1;
        end
        // no array access while still mapped onto the secure region
        if (ctrl[flash_prot_pkg::CTRL_SEC_BIT] &&
            !flash_prot_pkg::in_first_sector(addr_reg)) refuse = 1'b1;
    end

    // ------------------------------------------------------------
    // register next values
    // ------------------------------------------------------------
    always_comb begin
        next_addr_reg = addr_reg;
        next_wdata_reg = wdata_reg;
        next_ctrl = ctrl;
        next_pmap = pmap;
        next_refused = refused;
        next_done = done;
        prdata = rd_en ? rd_mux : 32'h0000_0000;
        if (wr_en && !busy) begin
            if (paddr == flash_prot_pkg::ADDR_OFF)
                next_addr_reg = pwdata[AW-1:0];
            if (paddr == flash_prot_pkg::WDATA_OFF)
                next_wdata_reg = pwdata[DW-1:0];
            if (paddr == flash_prot_pkg::PMAP_OFF)
                next_pmap = pwdata;
        end
        // ctrl is taken even mid-cycle so high voltage can drop at once
        if (wr_en && paddr == flash_prot_pkg::CTRL_OFF)
            next_ctrl = pwdata[3:0];
        if (wr_en && paddr == flash_prot_pkg::STATUS_OFF) begin
            if (pwdata[flash_prot_pkg::STAT_REFUSED_BIT]) next_refused = 1'b0;
            if (pwdata[flash_prot_pkg::STAT_DONE_BIT]) next_done = 1'b0;
        end
        if (start) next_done = 1'b0;
        // sets after clears so a same-cycle event wins
        if (start && refuse) next_refused = 1'b1;
        if (state == ST_HOLD) next_done = 1'b1;
        // identification read of a group address updates the map
        if (state == ST_SETTLE && cnt == 3'(0) &&
            op == flash_prot_pkg::OP_VERIFY)
            next_pmap[flash_prot_pkg::group_of(addr_reg)] =
                dq_sync[7:0] == flash_prot_pkg::PROT_CODE;
    end

    // ------------------------------------------------------------
    // flash cycle sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_op = op;
        next_cnt = cnt;
        next_rdata_reg = rdata_reg;
        case (state)
            ST_IDLE: begin
                if (start && !refuse) begin
                    next_op = flash_prot_pkg::op_t'(pwdata[1:0]);
                    next_state = ST_SETUP;
                end
            end
            ST_SETUP: begin
                next_cnt = 3'(flash_prot_pkg::STROBE_CYC - 1);
                next_state = ST_STROBE;
            end
            ST_STROBE: begin
                if (cnt != 3'(0)) begin
                    next_cnt = cnt - 3'(1);
                end else if (op == flash_prot_pkg::OP_READ ||
                             op == flash_prot_pkg::OP_VERIFY) begin
                    // wait out synchroniser latency before sampling
                    next_cnt = 3'(flash_prot_pkg::SYNC_CYC);
                    next_state = ST_SETTLE;
                end else begin
                    next_state = ST_HOLD;
                end
            end
            ST_SETTLE: begin
                if (cnt != 3'(0)) begin
                    next_cnt = cnt - 3'(1);
                end else begin
                    next_rdata_reg = dq_sync;
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_reg <= '0;
            wdata_reg <= '0;
            ctrl <= flash_prot_pkg::CTRL_RESET;
            rdata_reg <= '0;
            pmap <= flash_prot_pkg::PMAP_RESET;
            refused <= 1'b0;
            done <= 1'b0;
            state <= ST_IDLE;
            op <= flash_prot_pkg::OP_READ;
            cnt <= '0;
        end else begin
            addr_reg <= next_addr_reg;
            wdata_reg <= next_wdata_reg;
            ctrl <= next_ctrl;
            rdata_reg <= next_rdata_reg;
            pmap <= next_pmap;
            refused <= next_refused;
            done <= next_done;
            state <= next_state;
            op <= next_op;
            cnt <= next_cnt;
        end
    end

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    logic is_write;
    assign is_write = op == flash_prot_pkg::OP_WRITE ||
                      op == flash_prot_pkg::OP_UNPROT;
    assign flash_addr = addr_reg;
    assign dq_out = wdata_reg;
    assign dq_oe = busy && is_write;
    assign ce_n = !(state inside {ST_SETUP, ST_STROBE, ST_SETTLE});
    assign we_n = !(state == ST_STROBE && is_write);
    assign oe_n = !(state inside {ST_STROBE, ST_SETTLE} && !is_write);
    // level steered by software; secure lock works at either level
    assign hv_request = ctrl[flash_prot_pkg::CTRL_HV_BIT];
    assign flash_reset_n = ctrl[flash_prot_pkg::CTRL_RST_BIT];
    assign guard_n = ctrl[flash_prot_pkg::CTRL_WP_BIT];

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence unprot_cmd;
        start && pwdata[1:0] == flash_prot_pkg::OP_UNPROT && !busy;
    endsequence

    sequence write_strobe;
        !we_n && !ce_n && oe_n;
    endsequence

    unprot_needs_hv_a: assert property (
        unprot_cmd and !ctrl[flash_prot_pkg::CTRL_HV_BIT] |=>
            refused && state == ST_IDLE)
        else $error("unprotect issued without high voltage");

    unprot_all_prot_a: assert property (
        unprot_cmd and pmap != 32'hFFFF_FFFF |=>
            refused && state == ST_IDLE)
        else $error("unprotect issued with unprotected groups");

    secure_exit_a: assert property (
        start && !busy && ctrl[flash_prot_pkg::CTRL_SEC_BIT] &&
        !flash_prot_pkg::in_first_sector(addr_reg) |=> ce_n && refused)
        else $error("array access while secure region mapped");

    write_timing_a: assert property (
        $fell(we_n) |-> write_strobe [*2] ##1 we_n ##1 ce_n)
        else $error("write strobe length wrong");

    read_sample_a: assert property (
        $fell(oe_n) |-> !oe_n [*6] ##1 oe_n && done == 1'b0 ##1 done)
        else $error("read strobe or done timing wrong");

    verify_map_a: assert property (
        state == ST_SETTLE && cnt == 3'(0) &&
        op == flash_prot_pkg::OP_VERIFY |=>
        pmap[flash_prot_pkg::group_of(addr_reg)] ==
            ($past(dq_sync[7:0]) == flash_prot_pkg::PROT_CODE))
        else $error("group map not updated from verify read");

    hv_follows_ctrl_a: assert property (
        wr_en && paddr == flash_prot_pkg::CTRL_OFF |=>
        hv_request == $past(pwdata[flash_prot_pkg::CTRL_HV_BIT]))
        else $error("high voltage request does not follow ctrl");

    no_drive_on_read_a: assert property (
        !oe_n |-> !dq_oe && we_n)
        else $error("bus contention during read");

endmodule

// ===== flash_prot_pkg.sv
// Purpose: constants shared by the flash protection host controller
// Assumes: 10 MHz pclk, 32-bit apb, x16 flash with 22 word address bits
// Notes:   register offsets are byte addresses of aligned words
package flash_prot_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int STROBE_NS = 120;
    // least time, so round up
    localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_CYC = 3;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_OFF = 8'h00;
    localparam logic [7:0] WDATA_OFF = 8'h04;
    localparam logic [7:0] CTRL_OFF = 8'h08;
    localparam logic [7:0] CMD_OFF = 8'h0C;
    localparam logic [7:0] STATUS_OFF = 8'h10;
    localparam logic [7:0] RDATA_OFF = 8'h14;
    localparam logic [7:0] PMAP_OFF = 8'h18;

    // ctrl fields
    localparam int CTRL_HV_BIT = 0;
    localparam int CTRL_WP_BIT = 1;
    localparam int CTRL_RST_BIT = 2;
    localparam int CTRL_SEC_BIT = 3;
    localparam logic [3:0] CTRL_RESET = 4'h6;

    // status fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_REFUSED_BIT = 1;
    localparam int STAT_DONE_BIT = 2;

    // ------------------------------------------------------------
    // flash geometry and codes
    // ------------------------------------------------------------
    localparam int ADDR_W = 22;
    localparam int DATA_W = 16;
    localparam int GROUPS = 32;
    localparam int GROUP_LSB = 17;
    localparam int SECTOR_LSB = 15;
    localparam logic [7:0] PROT_CODE = 8'h01;
    localparam logic [31:0] PMAP_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        OP_READ = 2'h0,
        OP_WRITE = 2'h1,
        OP_VERIFY = 2'h2,
        OP_UNPROT = 2'h3
    } op_t;

    function automatic logic [4:0] group_of(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:GROUP_LSB];
    endfunction

    function automatic logic in_first_sector(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:SECTOR_LSB] == '0;
    endfunction

endpackage

// ===== flash_pin_sync.sv
// Purpose: three-stage synchroniser for flash data pins
// Assumes: single pclk domain
// Notes:   output moves only once stages two and three agree
`timescale 1ns/1ns
module flash_pin_sync #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pins
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_sync
);

    logic [WIDTH-1:0] s1, s2, s3;
    logic [WIDTH-1:0] next_pin_sync;

    if (WIDTH < 1) begin : g_width_chk
        $error("width must be positive");
    end

    always_comb begin
        next_pin_sync = pin_sync;
        if (s2 == s3) begin
            next_pin_sync = s3;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            pin_sync <= '0;
        end else begin
            s1 <= pin_in;
            s2 <= s1;
            s3 <= s2;
            pin_sync <= next_pin_sync;
        end
    end

endmodule

// ===== flash_dev_model.sv
// Purpose: behavioural flash device facing the protection host
// Assumes: hv_request high means reset pin at high_voltage_level
// Notes:   one-write commands, no unlock cycles; 0088 enter, 0090 exit
`timescale 1ns/1ns
module flash_dev_model #(
    parameter bit FACTORY_LOCK = 1'b1,
    parameter bit GUARD_FIRST = 1'b1
) (
    // flash pins
    input wire logic [21:0] flash_addr,
    input wire logic [15:0] dq_out,
    input wire logic dq_oe,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic flash_reset_n,
    input wire logic hv_request,
    input wire logic guard_n,
    output logic [15:0] dq_in
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [31:0] prot = 32'h0000_0000;
    logic [15:0] mem [int];
    logic [15:0] sec_mem [128];
    logic sec = 1'b0;
    logic sec_lock = FACTORY_LOCK;
    logic armed = 1'b0;
    logic [15:0] rd_q = 16'h0000;
    logic [15:0] last = 16'h0000;
    logic [15:0] wd;
    wire [4:0] grp = flash_addr[21:17];
    wire first = flash_addr[21:15] == 7'h00;
    wire guarded = GUARD_FIRST ? first : &flash_addr[21:15];
    // undriven wire shows the inverse of its last value
    assign wd = dq_oe ? dq_out : ~last;
    assign dq_in = (!ce_n && !oe_n) ? rd_q : ~last;
    // serial value is arbitrary; upper offsets read erased
    initial begin
        for (int i = 0; i < 128; i++)
            sec_mem[i] = i < 8 ? 16'h5a00 + 16'(i) : 16'hffff;
    end
    // ------------------------------------------------------------
    // bus cycles
    // ------------------------------------------------------------
    function automatic logic [15:0] rd_val();
        if (hv_request && flash_addr[1:0] == 2'h2)
            return {15'h0000, prot[grp]};
        if (hv_request && flash_addr[1:0] == 2'h3)
            return {8'h00, FACTORY_LOCK, 7'h18};
        if (sec && first)
            return sec_mem[flash_addr[6:0]];
        return mem.exists(flash_addr) ? mem[flash_addr] : 16'hffff;
    endfunction
    always @(negedge oe_n) rd_q = rd_val();
    always @(posedge oe_n) last = rd_q;
    always @(negedge flash_reset_n) sec = 1'b0;
    always @(negedge we_n) armed = !ce_n;
    always @(posedge we_n) begin
        if (armed) begin
            if (wd == 16'h0088) sec = 1'b1;
            else if (wd == 16'h0090) sec = 1'b0;
            else if (wd == 16'h0060 && sec) sec_lock = 1'b1;
            else if (wd == 16'h0060 && hv_request) begin
                if (flash_addr[6]) prot = 32'h0000_0000;
                else prot[grp] = 1'b1;
            end else if (sec && first) begin
                if (!sec_lock) sec_mem[flash_addr[6:0]] = wd;
            end else if (!(!hv_request && prot[grp])
                && !(!guard_n && guarded))
                mem[flash_addr] = wd;
        end
        armed = 1'b0;
    end
endmodule

// ===== tb_flash_prot_host.sv
// Purpose: self-checking bench for flash_prot_host with a device model
// Assumes: a flash cycle ends within 10 pclk of its command write
// Notes:   each apb read queues an expected value and a mask
`timescale 1ns/1ns
module tb_flash_prot_host;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [21:0] flash_addr;
    logic [15:0] dq_out;
    logic [15:0] dq_in;
    logic dq_oe, ce_n, oe_n, we_n, flash_reset_n, hv_request, guard_n;
    logic [32:0] exp_q [$];
    logic [32:0] msk_q [$];
    int n_fail = 0;
    int cmp_count = 0;
    logic [31:0] lfsr = 32'h0000_dbf5;
    logic [15:0] v;
    logic [15:0] w;

    flash_prot_host u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flash_addr(flash_addr), .dq_out(dq_out), .dq_oe(dq_oe),
        .dq_in(dq_in), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .flash_reset_n(flash_reset_n), .hv_request(hv_request),
        .guard_n(guard_n));
    flash_dev_model u_dev (.flash_addr(flash_addr), .dq_out(dq_out),
        .dq_oe(dq_oe), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .flash_reset_n(flash_reset_n), .hv_request(hv_request),
        .guard_n(guard_n), .dq_in(dq_in));

    initial begin
        forever #50 pclk = ~pclk;
    end
    // ------------------------------------------------------------
    // checking
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [32:0] seen,
                       input logic [32:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            chk($sformatf("read %h", paddr),
                {pslverr, prdata} & msk_q[0], exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        end_sim();
    end
    // ------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e,
                      input logic [32:0] m = 33'h1_ffff_ffff);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        apb(1'b0, a, 32'h0000_0000);
    endtask
    task automatic op(input logic [1:0] k, input logic [21:0] a,
                      input logic [15:0] d, input logic refused);
        wr(flash_prot_pkg::ADDR_OFF, {10'h000, a});
        wr(flash_prot_pkg::WDATA_OFF, {16'h0000, d});
        wr(flash_prot_pkg::CMD_OFF, {30'h0000_0000, k});
        repeat (10) @(posedge pclk);
        if (refused) rd(flash_prot_pkg::STATUS_OFF, 2, 33'h0_0000_0003);
        else rd(flash_prot_pkg::STATUS_OFF, 32'h0000_0004);
        wr(flash_prot_pkg::STATUS_OFF, 32'h0000_0006);
    endtask
    task automatic fread(input logic [21:0] a, input logic [15:0] e);
        op(2'h0, a, 16'h0000, 1'b0);
        rd(flash_prot_pkg::RDATA_OFF, {16'h0000, e});
    endtask
    task automatic pmap(input logic [31:0] e);
        rd(flash_prot_pkg::PMAP_OFF, e);
    endtask
    task automatic ctrl(input logic [3:0] c);
        wr(flash_prot_pkg::CTRL_OFF, {28'h000_0000, c});
    endtask
    // top bit forced so a random word never matches a command code
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[15:0] | 16'h8000;
    endfunction
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(flash_prot_pkg::CTRL_OFF, {28'h000_0000,
            flash_prot_pkg::CTRL_RESET});
        pmap(flash_prot_pkg::PMAP_RESET);
        rd(8'h1c, 33'h1_0000_0000, 33'h1_0000_0000);
        ctrl(4'h7);
        op(2'h2, 22'h00_0002, 16'h0000, 1'b0);
        op(2'h2, 22'h3e_0002, 16'h0000, 1'b0);
        pmap(32'h0000_0000);
        op(2'h1, 22'h0a_0000, 16'h0060, 1'b0);
        op(2'h2, 22'h0a_0002, 16'h0000, 1'b0);
        pmap(32'h0000_0020);
        ctrl(4'h6);
        v = rnd();
        w = rnd();
        op(2'h1, 22'h0b_8004, v, 1'b0);
        fread(22'h0b_8004, 16'hffff);
        op(2'h1, 22'h0c_0004, v, 1'b0);
        fread(22'h0c_0004, v);
        ctrl(4'h7);
        op(2'h1, 22'h0a_0004, w, 1'b0);
        fread(22'h0a_0004, w);
        ctrl(4'h6);
        op(2'h1, 22'h0a_0004, v, 1'b0);
        fread(22'h0a_0004, w);
        ctrl(4'h4);
        op(2'h1, 22'h00_0010, v, 1'b0);
        fread(22'h00_0010, 16'hffff);
        ctrl(4'h5);
        op(2'h1, 22'h00_0010, v, 1'b0);
        fread(22'h00_0010, 16'hffff);
        ctrl(4'h6);
        op(2'h1, 22'h00_0010, w, 1'b0);
        fread(22'h00_0010, w);
        ctrl(4'h7);
        op(2'h3, 22'h00_0040, 16'h0060, 1'b1);
        for (int g = 0; g < 32; g++) begin
            op(2'h1, {5'(g), 17'h0_0000}, 16'h0060, 1'b0);
            op(2'h2, {5'(g), 17'h0_0002}, 16'h0000, 1'b0);
        end
        pmap(32'hffff_ffff);
        ctrl(4'h6);
        op(2'h3, 22'h00_0040, 16'h0060, 1'b1);
        ctrl(4'h7);
        op(2'h3, 22'h00_0040, 16'h0060, 1'b0);
        op(2'h2, 22'h12_0002, 16'h0000, 1'b0);
        pmap(32'hffff_fdff);
        ctrl(4'h6);
        op(2'h1, 22'h0a_0004, v, 1'b0);
        fread(22'h0a_0004, v);
        op(2'h1, 22'h00_0000, 16'h0088, 1'b0);
        ctrl(4'he);
        for (int i = 0; i < 8; i++)
            fread(22'(i), 16'h5a00 + 16'(i));
        op(2'h1, 22'h02_0000, v, 1'b1);
        op(2'h1, 22'h00_0001, v, 1'b0);
        fread(22'h00_0001, 16'h5a01);
        fread(22'h00_0008, 16'hffff);
        ctrl(4'hf);
        fread(22'h00_0003, 16'h0098);
        ctrl(4'h2);
        ctrl(4'h6);
        fread(22'h00_0010, w);
        end_sim();
    end
endmodule
